// ==== common/bpw_defs.vh ====
/*
 Constants of the bridge PWM waveform block: register byte offsets,
 control field positions, mode codes and reset values.
 Assumes it is included once per compile unit by its bare name.
*/
`ifndef BPW_DEFS_VH
`define BPW_DEFS_VH

// Register byte offsets
`define BPW_OFS_CTRL     5'h00
`define BPW_OFS_DBR      5'h04
`define BPW_OFS_DBF      5'h08
`define BPW_OFS_SRCEN    5'h0C
`define BPW_OFS_STATUS   5'h10
`define BPW_OFS_STEER    5'h14
`define BPW_OFS_STEERACT 5'h18

// Control register fields
`define BPW_CTRL_EN      7
`define BPW_CTRL_LOAD    6
`define BPW_CTRL_DBRE    5
`define BPW_CTRL_DBFE    4
`define BPW_CTRL_MODE_HI 3
`define BPW_CTRL_MODE_LO 0

// Mode codes
`define BPW_MODE_PP      4'h2
`define BPW_MODE_CPP     4'h3
`define BPW_MODE_FBPP    4'h4
`define BPW_MODE_FBCPP   4'h5
`define BPW_MODE_SKIP    4'h6
`define BPW_MODE_CSKIP   4'h7
`define BPW_MODE_FWD     4'h8
`define BPW_MODE_REV     4'h9

// Output mask bits {F,E,D,C,B,A}
`define BPW_MASK_A       6'h01
`define BPW_MASK_B       6'h02
`define BPW_MASK_C       6'h04
`define BPW_MASK_D       6'h08
`define BPW_MASK_E       6'h10
`define BPW_MASK_F       6'h20

// Reset values
`define BPW_RST_BYTE     8'h00
`define BPW_RST_SRCEN    4'h0

`endif

// ==== hw/bpw_bridge_pwm.v ====
/*
 Waveform generator for the alternating bridge modes, pulse-skipping
 modes and the compatible full-bridge mode, with an Avalon-MM slave.
 Assumes period, rise and fall events are one-cycle pulses synchronous
 to clk from an external time base; qualifying sources are synchronous.
*/
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "bpw_defs.vh"

module bpw_bridge_pwm (
    input  wire        clk,
    input  wire        rst_b,
    // Avalon-MM slave
    input  wire [4:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output wire [31:0] readdata,
    output wire        waitrequest,
    // Time base events
    input  wire        periodEvt,
    input  wire        riseEvt,
    input  wire        fallEvt,
    input  wire [3:0]  riseSrc,
    // Gate drive outputs
    output wire        out_a,
    output wire        out_b,
    output wire        out_c,
    output wire        out_d,
    output wire        out_e,
    output wire        out_f
);

    // Primary set for a mode and period parity
    function [5:0] primMask;
        input [3:0] mode;
        input       odd;
        begin
            case (mode)
                `BPW_MODE_PP,
                `BPW_MODE_CPP:   primMask = odd ? `BPW_MASK_A : `BPW_MASK_B;
                `BPW_MODE_FBPP,
                `BPW_MODE_FBCPP: primMask = odd ? (`BPW_MASK_A | `BPW_MASK_C)
                                                : (`BPW_MASK_B | `BPW_MASK_D);
                `BPW_MODE_SKIP,
                `BPW_MODE_CSKIP: primMask = `BPW_MASK_A;
                // Bridge and unknown modes drive nothing here
                default:         primMask = 6'h00;
            endcase
        end
    endfunction

    // Complementary set for a mode and period parity
    function [5:0] compMask;
        input [3:0] mode;
        input       odd;
        begin
            case (mode)
                `BPW_MODE_CPP,
                `BPW_MODE_FBCPP: compMask = odd ? `BPW_MASK_E : `BPW_MASK_F;
                `BPW_MODE_CSKIP: compMask = `BPW_MASK_B;
                // Single-set modes have no second set
                default:         compMask = 6'h00;
            endcase
        end
    endfunction

    // Non-bridge modes that honour the dead-band enables
    // Modes 2, 4 and 6 ignore the enables by choice
    function dbMode;
        input [3:0] mode;
        begin
            dbMode = (mode == `BPW_MODE_CPP) || (mode == `BPW_MODE_FBCPP) ||
                     (mode == `BPW_MODE_CSKIP);
        end
    endfunction

    // Bus slave state
    reg         waitReqQ;      // High except in the answer cycle
    reg  [31:0] rdDataQ;       // Read data, valid with waitrequest low

    // Software registers
    reg  [7:0]  ctrlQ;         // Enable, dead-band enables, mode
    reg  [7:0]  dbrBufQ;       // Rising dead-band buffer
    reg  [7:0]  dbfBufQ;       // Falling dead-band buffer
    reg  [3:0]  srcEnBufQ;     // Qualifying source enable buffer
    reg  [7:0]  steerBufQ;     // Steering buffer
    reg  [7:0]  dbrActQ;       // Active rising dead-band count
    reg  [7:0]  dbfActQ;       // Active falling dead-band count
    reg  [3:0]  srcEnActQ;     // Active qualifying source enables
    reg  [7:0]  steerActQ;     // Active steering copy

    // Waveform state
    reg  [5:0]  outQ, outD;    // Output levels {F,E,D,C,B,A}
    reg  [5:0]  pendQ, pendD;  // Outputs waiting for dead band
    reg  [7:0]  cntQ, cntD;    // Shared dead-band counter
    reg         parQ, parD;    // Period parity, 1 = odd
    reg         seenQ, seenD;  // A period event seen since enable
    reg         qualQ, qualD;  // Current period qualified
    reg         pwmQ, pwmD;    // Modulated level in bridge mode
    reg         dirQ, dirD;    // Bridge direction, 1 = reverse
    reg         trQ, trD;      // Bridge direction change running
    reg  [3:0]  modeQ;         // Mode seen last cycle

    // Decoded control
    wire [3:0]  mode     = ctrlQ[`BPW_CTRL_MODE_HI:`BPW_CTRL_MODE_LO];
    wire        enable   = ctrlQ[`BPW_CTRL_EN];
    wire        dbRiseOn = ctrlQ[`BPW_CTRL_DBRE];
    wire        dbFallOn = ctrlQ[`BPW_CTRL_DBFE];
    wire        isBridge = (mode == `BPW_MODE_FWD) || (mode == `BPW_MODE_REV);
    wire        wasBridge = (modeQ == `BPW_MODE_FWD) || (modeQ == `BPW_MODE_REV);
    wire        isSkip   = (mode == `BPW_MODE_SKIP) || (mode == `BPW_MODE_CSKIP);
    wire        wantRev  = (mode == `BPW_MODE_REV);

    // Bus access decode
    wire        wrStrobe = write && !waitReqQ && byteenable[0];
    wire        wrCtrl   = wrStrobe && (address == `BPW_OFS_CTRL);

    // Combinational event helpers
    reg         oddNow;        // Parity in force this cycle
    reg         seenNow;       // Event seen, including this cycle
    reg         qualNow;       // Qualification in force this cycle
    reg  [5:0]  pm;            // Primary set for this event
    reg  [5:0]  cm;            // Complementary set for this event

    // Next-state of the waveform engine
    always @* begin
        outD    = outQ;
        pendD   = pendQ;
        cntD    = cntQ;
        parD    = parQ;
        seenD   = seenQ;
        qualD   = qualQ;
        pwmD    = pwmQ;
        dirD    = dirQ;
        trD     = trQ;
        oddNow  = parQ;
        seenNow = seenQ;
        qualNow = qualQ;
        pm      = 6'h00;
        cm      = 6'h00;
        // Defaults above keep every path assigned
        if (!enable) begin
            // Idle: everything inactive, parity restarts
            outD  = 6'h00;
            pendD = 6'h00;
            cntD  = 8'h00;
            parD  = 1'b0;
            seenD = 1'b0;
            qualD = 1'b0;
            pwmD  = 1'b0;
            dirD  = wantRev;
            trD   = 1'b0;
        end else if (mode != modeQ && !(isBridge && wasBridge)) begin
            // Mode switch: restart cleanly rather than glitch a gate
            outD  = 6'h00;
            pendD = 6'h00;
            cntD  = 8'h00;
            pwmD  = 1'b0;
            dirD  = wantRev;
            trD   = 1'b0;
        end else begin
            // Period event flips parity; first one marks odd
            if (periodEvt) begin
                parD  = ~parQ;
                seenD = 1'b1;
                // Qualification latched at the period edge only
                qualD = |(riseSrc & srcEnActQ);
            end
            oddNow  = parD;
            seenNow = seenD;
            qualNow = qualD;
            if (isBridge) begin
                // Modulated level follows single-phase events
                if (riseEvt && seenNow) begin
                    pwmD = 1'b1;
                end
                if (fallEvt && seenNow) begin
                    pwmD = 1'b0;
                end
                // Both legs of one side must never overlap
                if (trQ) begin
                    // Counting out the direction change
                    if (cntQ <= 8'h01) begin
                        trD  = 1'b0;
                        dirD = wantRev;
                        cntD = 8'h00;
                    end else begin
                        cntD = cntQ - 8'h01;
                    end
                end else if (wantRev != dirQ) begin
                    // Direction request: pick the counter by direction
                    if (wantRev) begin
                        cntD = dbFallOn ? dbfActQ : 8'h00;
                    end else begin
                        cntD = dbRiseOn ? dbrActQ : 8'h00;
                    end
                    if (cntD == 8'h00) begin
                        // Zero count or dead band off: switch at once
                        dirD = wantRev;
                    end else begin
                        // Hold outputs dark for the loaded count
                        trD = 1'b1;
                    end
                end
                // Only A-D driven; all off during the change
                if (trD || !seenNow) begin
                    outD = 6'h00;
                end else if (dirD) begin
                    // Reverse: B modulated, C held on
                    outD = {4'h0, pwmD, 1'b0} | `BPW_MASK_C;
                end else begin
                    // Forward: A modulated, D held on
                    outD = {5'h00, pwmD} | `BPW_MASK_D;
                end
            end else begin
                // Dead band running: assert the waiting set on expiry
                if (pendQ != 6'h00) begin
                    // A count of N asserts at the Nth edge after the event
                    if (cntQ <= 8'h01) begin
                        outD  = outQ | pendQ;
                        pendD = 6'h00;
                        cntD  = 8'h00;
                    end else begin
                        // Still counting
                        cntD = cntQ - 8'h01;
                    end
                end
                pm = primMask(mode, oddNow);
                cm = compMask(mode, oddNow);
                // Rising: complement off, wait, primary on
                if (riseEvt && seenNow && (!isSkip || qualNow)) begin
                    outD = outD & ~cm;
                    if (dbMode(mode) && dbRiseOn && dbrActQ != 8'h00) begin
                        // Primary waits out the rising count
                        pendD = pm;
                        cntD  = dbrActQ;
                    end else begin
                        // No dead band: primary on at this edge
                        outD  = outD | pm;
                        pendD = 6'h00;
                    end
                end
                // Falling: primary off, wait, complement on
                if (fallEvt && seenNow) begin
                    outD = outD & ~pm;
                    if (dbMode(mode) && dbFallOn && dbfActQ != 8'h00) begin
                        // Complement waits out the falling count
                        pendD = cm;
                        cntD  = dbfActQ;
                    end else begin
                        // No dead band: complement on at this edge
                        outD  = outD | cm;
                        pendD = 6'h00;
                    end
                end
            end
        end
    end

    // Waveform state registers
    always @(posedge clk) begin
        if (!rst_b) begin
            // Synchronous reset: every gate quiet
            outQ  <= 6'h00;
            pendQ <= 6'h00;
            cntQ  <= 8'h00;
            parQ  <= 1'b0;
            seenQ <= 1'b0;
            qualQ <= 1'b0;
            pwmQ  <= 1'b0;
            dirQ  <= 1'b0;
            trQ   <= 1'b0;
            modeQ <= 4'h0;
        end else begin
            outQ  <= outD;
            pendQ <= pendD;
            cntQ  <= cntD;
            parQ  <= parD;
            seenQ <= seenD;
            qualQ <= qualD;
            pwmQ  <= pwmD;
            dirQ  <= dirD;
            trQ   <= trD;
            // Mode tracked even while disabled
            modeQ <= mode;
        end
    end

    // Register writes; buffers go live only on a load write
    always @(posedge clk) begin
        if (!rst_b) begin
            ctrlQ     <= `BPW_RST_BYTE;
            dbrBufQ   <= `BPW_RST_BYTE;
            dbfBufQ   <= `BPW_RST_BYTE;
            srcEnBufQ <= `BPW_RST_SRCEN;
            steerBufQ <= `BPW_RST_BYTE;
            dbrActQ   <= `BPW_RST_BYTE;
            dbfActQ   <= `BPW_RST_BYTE;
            srcEnActQ <= `BPW_RST_SRCEN;
            steerActQ <= `BPW_RST_BYTE;
        end else begin
            if (wrCtrl) begin
                // Load bit is a strobe and never stored
                ctrlQ <= writedata[7:0] & ~(8'h01 << `BPW_CTRL_LOAD);
                if (writedata[`BPW_CTRL_LOAD]) begin
                    dbrActQ   <= dbrBufQ;
                    dbfActQ   <= dbfBufQ;
                    srcEnActQ <= srcEnBufQ;
                    steerActQ <= steerBufQ;
                end
            end
            // Rising dead-band buffer
            if (wrStrobe && address == `BPW_OFS_DBR) begin
                dbrBufQ <= writedata[7:0];
            end
            // Falling dead-band buffer
            if (wrStrobe && address == `BPW_OFS_DBF) begin
                dbfBufQ <= writedata[7:0];
            end
            // Source enables; software picks the sources
            if (wrStrobe && address == `BPW_OFS_SRCEN) begin
                srcEnBufQ <= writedata[3:0];
            end
            // Steering is only stored; no mode here uses it
            if (wrStrobe && address == `BPW_OFS_STEER) begin
                steerBufQ <= writedata[7:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    reg [31:0] rdMux;
    always @* begin
        rdMux = 32'h00000000;
        case (address)
            `BPW_OFS_CTRL:     rdMux = {24'h000000, ctrlQ};
            `BPW_OFS_DBR:      rdMux = {24'h000000, dbrBufQ};
            `BPW_OFS_DBF:      rdMux = {24'h000000, dbfBufQ};
            `BPW_OFS_SRCEN:    rdMux = {28'h0000000, srcEnBufQ};
            // Status packs live engine state for software
            `BPW_OFS_STATUS:   rdMux = {18'h00000, outQ, 3'h0, trQ, dirQ,
                                        qualQ, seenQ, parQ};
            `BPW_OFS_STEER:    rdMux = {24'h000000, steerBufQ};
            `BPW_OFS_STEERACT: rdMux = {24'h000000, steerActQ};
            default:           rdMux = 32'h00000000;
        endcase
    end

    // Fixed one-wait-state handshake: cheap and easy to verify
    always @(posedge clk) begin
        if (!rst_b) begin
            waitReqQ <= 1'b1;
            rdDataQ  <= 32'h00000000;
        end else if (waitReqQ && (read || write)) begin
            // Take the request; read data captured now
            waitReqQ <= 1'b0;
            rdDataQ  <= rdMux;
        end else begin
            // Answer lasts one cycle only
            waitReqQ <= 1'b1;
        end
    end

    // Ports straight from flops
    assign waitrequest = waitReqQ;
    assign readdata    = rdDataQ;
    // Outputs {F,E,D,C,B,A} map bit for bit
    assign out_a       = outQ[0];
    assign out_b       = outQ[1];
    assign out_c       = outQ[2];
    assign out_d       = outQ[3];
    assign out_e       = outQ[4];
    assign out_f       = outQ[5];

endmodule

// ==== verification/bpw_monitor.sv ====
/*
 Port checker for the bridge PWM block: bus handshake, reset, overlap.
 Assumes it is bound to every bpw_bridge_pwm instance.
*/
`timescale 1ns/1ps

module bpw_monitor (
    input wire        clk,
    input wire        rst_b,
    input wire        read,
    input wire        write,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire        out_a,
    input wire        out_b,
    input wire        out_c,
    input wire        out_d,
    input wire        out_e,
    input wire        out_f
);
    // Bus: one wait state, then a one-cycle answer
    wait_answer_a: assert property (@(posedge clk) disable iff (!rst_b)
        (read || write) && waitrequest |=> !waitrequest) else $error("request not answered");
    wait_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        !waitrequest |=> waitrequest) else $error("answer longer than one cycle");
    wait_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
        !waitrequest |-> $past(read || write)) else $error("answer without request");
    read_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        waitrequest && $past(waitrequest) |-> $stable(readdata)) else $error("read data moved");
    read_upper_a: assert property (@(posedge clk) disable iff (!rst_b)
        readdata[31:14] == 18'h00000) else $error("unused read bits set");
    // Reset must quiet the bridge regardless of prior state
    reset_quiet_a: assert property (@(posedge clk)
        !rst_b |=> {out_f, out_e, out_d, out_c, out_b, out_a} == 6'h00 && waitrequest)
        else $error("outputs live after reset");
    // Both switches of one leg on means shoot-through
    drive_ae_a: assert property (@(posedge clk) disable iff (!rst_b)
        !(out_a && out_e)) else $error("a and e overlap");
    drive_bf_a: assert property (@(posedge clk) disable iff (!rst_b)
        !(out_b && out_f)) else $error("b and f overlap");
    drive_cd_a: assert property (@(posedge clk) disable iff (!rst_b)
        !(out_c && out_d)) else $error("c and d overlap");
    drive_ab_a: assert property (@(posedge clk) disable iff (!rst_b)
        !(out_a && out_b)) else $error("a and b overlap");
endmodule

bind bpw_bridge_pwm bpw_monitor uMon (.clk(clk), .rst_b(rst_b), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .out_a(out_a), .out_b(out_b),
    .out_c(out_c), .out_d(out_d), .out_e(out_e), .out_f(out_f));

// ==== verification/bpw_gate_model.sv ====
/*
 Gate driver stand-in: latches a fault if any bridge leg is driven
 both ways at once. Assumes active-high gate inputs on clk.
*/
`timescale 1ns/1ps

module bpw_gate_model (
    input  wire clk,
    input  wire rst_b,
    input  wire out_a,
    input  wire out_b,
    input  wire out_c,
    input  wire out_d,
    input  wire out_e,
    input  wire out_f,
    output reg  fault
);
    // Sticky, like a real driver's desaturation latch
    always @(posedge clk) begin
        if (!rst_b) begin
            fault <= 1'b0;
        end else if ((out_a & out_e) | (out_b & out_f) | (out_c & out_d) | (out_a & out_b)) begin
            fault <= 1'b1;
        end
    end
endmodule

// ==== verification/tb_bpw_bridge_pwm.sv ====
/*
 Self-checking bench for the bridge PWM block: mode table, dead band,
 skipping, direction change, registers. Assumes 50 ns clock.
*/
`timescale 1ns/1ps
`include "bpw_defs.vh"

module tb_bpw_bridge_pwm;
    reg         clk = 1'b0;
    reg         rst_b = 1'b0;
    reg  [4:0]  address = 5'h00;
    reg         read = 1'b0;
    reg         write = 1'b0;
    reg  [31:0] writedata = 32'h00000000;
    reg  [3:0]  byteenable = 4'hF;
    reg         periodEvt = 1'b0;
    reg         riseEvt = 1'b0;
    reg         fallEvt = 1'b0;
    reg  [3:0]  riseSrc = 4'h1;   // Source 0 high: periods qualify
    wire [31:0] readdata;
    wire        waitrequest;
    wire        out_a, out_b, out_c, out_d, out_e, out_f;
    wire        fault;
    wire [5:0]  outs = {out_f, out_e, out_d, out_c, out_b, out_a};
    integer     fails = 0;
    integer     comparisons = 0;
    integer     i, j;
    reg  [7:0]  q;                // Last read data
    // Rows: mode, outputs after odd rise, odd fall, even rise, even fall
    reg  [3:0]  mds [0:7] = '{`BPW_MODE_PP, `BPW_MODE_CPP, `BPW_MODE_FBPP, `BPW_MODE_FBCPP,
                             `BPW_MODE_SKIP, `BPW_MODE_CSKIP, `BPW_MODE_FWD, `BPW_MODE_REV};
    reg  [5:0]  exps [0:7][0:3] = '{'{6'h01, 6'h00, 6'h02, 6'h00}, '{6'h01, 6'h10, 6'h12, 6'h30},
                                  '{6'h05, 6'h00, 6'h0A, 6'h00}, '{6'h05, 6'h10, 6'h1A, 6'h30},
                                  '{6'h01, 6'h00, 6'h01, 6'h00}, '{6'h01, 6'h02, 6'h01, 6'h02},
                                  '{6'h09, 6'h08, 6'h09, 6'h08}, '{6'h06, 6'h04, 6'h06, 6'h04}};

    bpw_bridge_pwm uut (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .periodEvt(periodEvt), .riseEvt(riseEvt), .fallEvt(fallEvt),
        .riseSrc(riseSrc), .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d),
        .out_e(out_e), .out_f(out_f));

    bpw_gate_model uGate (.clk(clk), .rst_b(rst_b), .out_a(out_a), .out_b(out_b), .out_c(out_c),
        .out_d(out_d), .out_e(out_e), .out_f(out_f), .fault(fault));

    // Free-running clock
    initial begin
        forever #25 clk = ~clk;
    end

    // Verdict and end of run
    task test_done;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    task chkOut(input [5:0] e);
        begin
            comparisons = comparisons + 1;
            if (outs !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED outputs expected %h seen %h", e, outs);
            end
        end
    endtask

    task chkReg(input [7:0] e, input [7:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED register expected %h seen %h", e, g);
            end
        end
    endtask

    // One Avalon transfer; waitrequest and read data taken at one edge
    task bus(input we, input [4:0] a, input [7:0] d);
        begin
            @(posedge clk);
            address <= a;
            writedata <= {24'h000000, d};
            write <= we;
            read <= !we;
            @(posedge clk);
            while (waitrequest !== 1'b0) begin
                @(posedge clk);
            end
            q = readdata[7:0];
            write <= 1'b0;
            read <= 1'b0;
        end
    endtask

    // One-cycle event pulse {period, rise, fall}; returns after it lands
    task ev(input [2:0] e);
        begin
            @(posedge clk);
            {periodEvt, riseEvt, fallEvt} <= e;
            @(posedge clk);
            {periodEvt, riseEvt, fallEvt} <= 3'b000;
            #1;
        end
    endtask

    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask

    // Hang guard, far above the expected run length
    initial begin
        #2000000;
        fails = fails + 1;
        test_done;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, `BPW_OFS_STATUS, 8'h00);
        chkReg(8'h00, q);
        bus(1'b1, 5'h1C, 8'hFF);
        bus(1'b0, 5'h1C, 8'h00);
        chkReg(8'h00, q);
        bus(1'b1, `BPW_OFS_STEER, 8'h3C);
        bus(1'b1, `BPW_OFS_SRCEN, 8'h01);
        bus(1'b0, `BPW_OFS_STEERACT, 8'h00);
        chkReg(8'h00, q);
        bus(1'b1, `BPW_OFS_CTRL, 8'hC2);
        bus(1'b0, `BPW_OFS_STEERACT, 8'h00);
        chkReg(8'h3C, q);
        // Write with the low byte lane off must be ignored
        byteenable <= 4'hE;
        bus(1'b1, `BPW_OFS_DBR, 8'h55);
        byteenable <= 4'hF;
        bus(1'b0, `BPW_OFS_DBR, 8'h00);
        chkReg(8'h00, q);
        // Mode table: period, rise, fall, period, rise, fall
        for (i = 0; i < 8; i = i + 1) begin
            bus(1'b1, `BPW_OFS_CTRL, 8'h00);
            cyc(1);
            chkOut(6'h00);
            bus(1'b1, `BPW_OFS_CTRL, 8'hC0 | {4'h0, mds[i]});
            for (j = 0; j < 4; j = j + 1) begin
                if (j % 2 == 0)
                    ev(3'b100);
                ev((j % 2 == 0) ? 3'b010 : 3'b001);
                chkOut(exps[i][j]);
            end
        end
        // Dead band, rising 3 and falling 2 cycles
        bus(1'b1, `BPW_OFS_DBR, 8'h03);
        bus(1'b1, `BPW_OFS_DBF, 8'h02);
        bus(1'b0, `BPW_OFS_DBR, 8'h00);
        chkReg(8'h03, q);
        bus(1'b1, `BPW_OFS_CTRL, 8'h00);
        bus(1'b1, `BPW_OFS_CTRL, 8'hF3);
        ev(3'b100);
        ev(3'b010);
        cyc(2);
        chkOut(6'h00);
        cyc(1);
        chkOut(6'h01);
        ev(3'b001);
        cyc(1);
        chkOut(6'h00);
        cyc(1);
        chkOut(6'h10);
        // Complementary skipping, unqualified period in the middle
        bus(1'b1, `BPW_OFS_CTRL, 8'h00);
        bus(1'b1, `BPW_OFS_CTRL, 8'hC7);
        ev(3'b100);
        ev(3'b010);
        ev(3'b001);
        chkOut(6'h02);
        @(posedge clk);
        riseSrc <= 4'h2;
        ev(3'b100);
        ev(3'b010);
        chkOut(6'h02);
        ev(3'b001);
        chkOut(6'h02);
        @(posedge clk);
        riseSrc <= 4'h1;
        ev(3'b100);
        ev(3'b010);
        chkOut(6'h01);
        // Bridge reversals with unequal counts
        bus(1'b1, `BPW_OFS_DBR, 8'h04);
        bus(1'b1, `BPW_OFS_DBF, 8'h01);
        bus(1'b1, `BPW_OFS_CTRL, 8'h00);
        bus(1'b1, `BPW_OFS_CTRL, 8'hF8);
        ev(3'b100);
        chkOut(6'h08);
        bus(1'b1, `BPW_OFS_CTRL, 8'hF9);
        cyc(1);
        chkOut(6'h00);
        cyc(1);
        chkOut(6'h04);
        bus(1'b1, `BPW_OFS_CTRL, 8'hF8);
        cyc(3);
        chkOut(6'h00);
        cyc(1);
        chkOut(6'h00);
        cyc(1);
        chkOut(6'h08);
        // Latch is read before reset clears it
        chkReg(8'h00, {7'h00, fault});
        // Reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        cyc(2);
        chkOut(6'h00);
        @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, `BPW_OFS_CTRL, 8'h00);
        chkReg(8'h00, q);
        test_done;
    end
endmodule
